// >>> logic/pao_port_top.sv
// The APB register port is this design's own decision.
module pao_port_top
    import pao_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n,
    output logic [7:0] port_a_pullup,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe_n,
    output logic [7:0] port_b_pullup,
    output logic [7:0] port_a_digital,
    output logic [7:0] port_b_digital,
    output logic toggle_request,
    input wire logic two_wire_mode_active,
    input wire logic three_wire_mode_active,
    input wire logic serial_pin_remap,
    input wire logic clock_line_hold,
    input wire logic serial_toggle_enable,
    input wire logic start_detect_irq_enable,
    input wire logic serial_data_out,
    input wire logic serial_sda_out,
    input wire logic pin_change_enable,
    input wire logic [7:0] pin_change_mask_a,
    input wire logic external_irq1_input,
    input wire logic [7:0] analog_input_digital_off
);
    logic [7:0] port_a_direction_r;
    logic [7:0] port_a_output_latch_r;
    logic [7:0] port_b_direction_r;
    logic [7:0] port_b_output_latch_r;
    logic [7:0] core_control_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // Synchronised pin levels, already gated by input enable
    logic [7:0] a_sync;
    logic [7:0] b_sync;

    // Override pairs for port A
    logic [7:0] pu_ovr_en_a;
    logic [7:0] pu_ovr_val_a;
    logic [7:0] dir_ovr_en_a;
    logic [7:0] dir_ovr_val_a;
    logic [7:0] out_ovr_en_a;
    logic [7:0] out_ovr_val_a;
    logic [7:0] in_ovr_en_a;
    logic [7:0] in_ovr_val_a;
    logic [7:0] toggle_ovr_en_a;

    // Override pairs for port B
    logic [7:0] pu_ovr_en_b;
    logic [7:0] pu_ovr_val_b;
    logic [7:0] dir_ovr_en_b;
    logic [7:0] dir_ovr_val_b;
    logic [7:0] out_ovr_en_b;
    logic [7:0] out_ovr_val_b;
    logic [7:0] in_ovr_en_b;
    logic [7:0] in_ovr_val_b;

    logic [7:0] rd_nxt;
    logic pull_off;
    logic wr_en;
    logic setup_rd;
    logic setup_any;
    logic mapped;
    logic tw;
    logic [7:0] pcm;

    // Address decode shared by the error flag
    function automatic logic addr_known(input logic [31:0] a);
        addr_known = (a == PAO_OFF_B_LVL) || (a == PAO_OFF_B_DIR) || (a == PAO_OFF_B_LAT)
            || (a == PAO_OFF_A_LVL) || (a == PAO_OFF_A_DIR) || (a == PAO_OFF_A_LAT)
            || (a == PAO_OFF_CTRL);
    endfunction

    // Write strobe for one register
    function automatic logic wr_hit(
        input logic en,
        input logic [31:0] a,
        input logic [31:0] off
    );
        wr_hit = en && (a == off);
    endfunction

    assign pull_off = core_control_r[PAO_PULL_OFF_BIT];
    assign tw = two_wire_mode_active & serial_pin_remap;
    assign pcm = pin_change_mask_a & {PAO_PINS{pin_change_enable}};
    assign mapped = addr_known(paddr);
    assign wr_en = psel & penable & pwrite;
    assign setup_any = psel & ~penable;
    assign setup_rd = setup_any & ~pwrite;
    // Zero wait states: every register answers in one access cycle
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;

    // No pin of port A overrides its pull-up
    always_comb
    begin
        // A1 pull-up stays with latch and direction
        pu_ovr_en_a = 8'h00;
        pu_ovr_val_a = 8'h00;
    end

    always_comb
    begin
        // Upper pins keep their direction register
        dir_ovr_en_a = 8'h00;
        dir_ovr_val_a = 8'h00;
        dir_ovr_en_a[PAO_B2] = tw;
        dir_ovr_val_a[PAO_B2] = (clock_line_hold | port_b_output_latch_r[PAO_B2])
            & port_b_direction_r[PAO_B2] & serial_pin_remap;
        dir_ovr_en_a[PAO_B0] = tw;
        dir_ovr_val_a[PAO_B0] = (serial_sda_out | port_b_output_latch_r[PAO_B0])
            & port_b_direction_r[PAO_B0] & serial_pin_remap;
    end

    always_comb
    begin
        // No output override on A3 or upper pins
        out_ovr_en_a = 8'h00;
        out_ovr_val_a = 8'h00;
        // Clock pin driven low when enabled; the wire-and comes from direction
        out_ovr_en_a[PAO_B2] = two_wire_mode_active & port_b_direction_r[PAO_B2];
        // Serial data out on bit 1
        out_ovr_en_a[PAO_B1] = three_wire_mode_active & serial_pin_remap;
        out_ovr_val_a[PAO_B1] = serial_data_out & serial_pin_remap;
        out_ovr_en_a[PAO_B0] = tw & port_b_direction_r[PAO_B0];
    end

    always_comb
    begin
        // Masked pin change or digital-off on upper pins
        in_ovr_en_a = pcm | analog_input_digital_off;
        in_ovr_val_a = analog_input_digital_off;
        in_ovr_en_a[PAO_B3] = pcm[PAO_B3];
        in_ovr_val_a[PAO_B3] = 1'b0;
        in_ovr_en_a[PAO_B2] = pcm[PAO_B2] | external_irq1_input
            | analog_input_digital_off[PAO_B2]
            | (start_detect_irq_enable & serial_pin_remap);
        in_ovr_en_a[PAO_B0] = pcm[PAO_B0] | analog_input_digital_off[PAO_B0]
            | (start_detect_irq_enable & serial_pin_remap);
    end

    always_comb
    begin
        // Toggle held off on A0 and every pin but A2
        toggle_ovr_en_a = 8'h00;
        toggle_ovr_en_a[PAO_B2] = serial_toggle_enable & serial_pin_remap;
    end

    // The toggle itself lives in the serial block
    assign toggle_request = toggle_ovr_en_a[PAO_B2];

    // Port B alternate functions live outside this block
    always_comb
    begin
        pu_ovr_en_b = 8'h00;
        pu_ovr_val_b = 8'h00;
        dir_ovr_en_b = 8'h00;
        dir_ovr_val_b = 8'h00;
        out_ovr_en_b = 8'h00;
        out_ovr_val_b = 8'h00;
        in_ovr_en_b = 8'h00;
        in_ovr_val_b = 8'h00;
    end

    genvar gi;
    generate
        for (gi = 0; gi < PAO_PINS; gi++)
        begin : g_pin
            // Port A cell takes the override pairs
            pao_pin_cell u_a (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(port_a_in[gi]),
                .dir_bit(port_a_direction_r[gi]),
                .out_bit(port_a_output_latch_r[gi]),
                .pull_off(pull_off),
                .pu_ovr_en(pu_ovr_en_a[gi]),
                .pu_ovr_val(pu_ovr_val_a[gi]),
                .dir_ovr_en(dir_ovr_en_a[gi]),
                .dir_ovr_val(dir_ovr_val_a[gi]),
                .out_ovr_en(out_ovr_en_a[gi]),
                .out_ovr_val(out_ovr_val_a[gi]),
                .in_ovr_en(in_ovr_en_a[gi]),
                .in_ovr_val(in_ovr_val_a[gi]),
                .pad_out(port_a_out[gi]),
                .pad_oe_n(port_a_oe_n[gi]),
                .pullup_en(port_a_pullup[gi]),
                .din_sync(a_sync[gi])
            );
            pao_pin_cell u_b (
                .pclk(pclk),
                .presetn(presetn),
                .pin_in(port_b_in[gi]),
                .dir_bit(port_b_direction_r[gi]),
                .out_bit(port_b_output_latch_r[gi]),
                .pull_off(pull_off),
                .pu_ovr_en(pu_ovr_en_b[gi]),
                .pu_ovr_val(pu_ovr_val_b[gi]),
                .dir_ovr_en(dir_ovr_en_b[gi]),
                .dir_ovr_val(dir_ovr_val_b[gi]),
                .out_ovr_en(out_ovr_en_b[gi]),
                .out_ovr_val(out_ovr_val_b[gi]),
                .in_ovr_en(in_ovr_en_b[gi]),
                .in_ovr_val(in_ovr_val_b[gi]),
                .pad_out(port_b_out[gi]),
                .pad_oe_n(port_b_oe_n[gi]),
                .pullup_en(port_b_pullup[gi]),
                .din_sync(b_sync[gi])
            );
        end
    endgenerate

    assign port_a_digital = a_sync;
    assign port_b_digital = b_sync;

    // Writing ones to the level register toggles the latch bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_output_latch_r <= PAO_RST_PORT;
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_A_LAT))
        begin
            port_a_output_latch_r <= pwdata[7:0];
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_A_LVL))
        begin
            port_a_output_latch_r <= port_a_output_latch_r ^ pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_b_output_latch_r <= PAO_RST_PORT;
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_B_LAT))
        begin
            port_b_output_latch_r <= pwdata[7:0];
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_B_LVL))
        begin
            port_b_output_latch_r <= port_b_output_latch_r ^ pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_a_direction_r <= PAO_RST_PORT;
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_A_DIR))
        begin
            port_a_direction_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            port_b_direction_r <= PAO_RST_PORT;
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_B_DIR))
        begin
            port_b_direction_r <= pwdata[7:0];
        end
    end

    // Pull-up disable bit; bits 3 to 5 are stored too, the other control bits read zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_control_r <= PAO_RST_PORT;
        end
        else if (wr_hit(wr_en, paddr, PAO_OFF_CTRL))
        begin
            core_control_r <= pwdata[7:0] & PAO_CTRL_WMASK;
        end
    end

    always_comb
    begin
        case (paddr)
            PAO_OFF_B_LVL: rd_nxt = b_sync;
            PAO_OFF_B_DIR: rd_nxt = port_b_direction_r;
            PAO_OFF_B_LAT: rd_nxt = port_b_output_latch_r;
            PAO_OFF_A_LVL: rd_nxt = a_sync;
            PAO_OFF_A_DIR: rd_nxt = port_a_direction_r;
            PAO_OFF_A_LAT: rd_nxt = port_a_output_latch_r;
            PAO_OFF_CTRL: rd_nxt = core_control_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    // Read data captured in setup so it stands at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else if (setup_rd)
        begin
            prdata_r <= {24'h00_0000, rd_nxt};
        end
    end

    // Error flag rides with the access phase of an unmapped address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_r <= 1'b0;
        end
        else if (setup_any)
        begin
            pslverr_r <= ~mapped;
        end
        else if (!psel)
        begin
            pslverr_r <= 1'b0;
        end
    end
endmodule

// >>> logic/pao_pkg.sv
package pao_pkg;
    localparam logic [31:0] PAO_OFF_B_LVL = 32'h0000_0058;
    localparam logic [31:0] PAO_OFF_B_DIR = 32'h0000_005c;
    localparam logic [31:0] PAO_OFF_B_LAT = 32'h0000_0060;
    localparam logic [31:0] PAO_OFF_A_LVL = 32'h0000_0064;
    localparam logic [31:0] PAO_OFF_A_DIR = 32'h0000_0068;
    localparam logic [31:0] PAO_OFF_A_LAT = 32'h0000_006c;
    localparam logic [31:0] PAO_OFF_CTRL = 32'h0000_00d4;
    localparam logic [7:0] PAO_IDX_B_LVL = 8'h16;
    localparam logic [7:0] PAO_IDX_B_DIR = 8'h17;
    localparam logic [7:0] PAO_IDX_B_LAT = 8'h18;
    localparam logic [7:0] PAO_IDX_A_LVL = 8'h19;
    localparam logic [7:0] PAO_IDX_A_DIR = 8'h1a;
    localparam logic [7:0] PAO_IDX_A_LAT = 8'h1b;
    localparam logic [7:0] PAO_IDX_CTRL = 8'h35;
    localparam logic [7:0] PAO_RST_PORT = 8'h00;
    localparam logic [7:0] PAO_CTRL_WMASK = 8'h78;
    localparam int PAO_PULL_OFF_BIT = 6;
    localparam int PAO_PINS = 8;
    localparam int PAO_B0 = 0;
    localparam int PAO_B1 = 1;
    localparam int PAO_B2 = 2;
    localparam int PAO_B3 = 3;
endpackage

// >>> logic/pao_pin_cell.sv
module pao_pin_cell
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin_in,
    input wire logic dir_bit,
    input wire logic out_bit,
    input wire logic pull_off,
    input wire logic pu_ovr_en,
    input wire logic pu_ovr_val,
    input wire logic dir_ovr_en,
    input wire logic dir_ovr_val,
    input wire logic out_ovr_en,
    input wire logic out_ovr_val,
    input wire logic in_ovr_en,
    input wire logic in_ovr_val,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pullup_en,
    output logic din_sync
);
    logic dir_eff;
    logic s1_r;
    logic s2_r;
    logic in_en;

    assign dir_eff = dir_ovr_en ? dir_ovr_val : dir_bit;
    assign pad_out = out_ovr_en ? out_ovr_val : out_bit;
    assign pad_oe_n = ~dir_eff;
    assign pullup_en = (pu_ovr_en ? pu_ovr_val : (~dir_eff & out_bit)) & ~pull_off;
    // Input disabled when override says so, avoiding analog crowbar current
    assign in_en = in_ovr_en ? ~in_ovr_val : 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
        end
    end

    assign din_sync = in_en & s2_r;
endmodule

// >>> dv/pao_port_props.sv
module pao_port_props
    import pao_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe_n,
    input wire logic [7:0] port_a_pullup,
    input wire logic [7:0] port_b_pullup,
    input wire logic [7:0] port_a_digital,
    input wire logic two_wire_mode_active,
    input wire logic three_wire_mode_active,
    input wire logic serial_pin_remap,
    input wire logic clock_line_hold,
    input wire logic serial_data_out,
    input wire logic pin_change_enable,
    input wire logic [7:0] pin_change_mask_a,
    input wire logic [7:0] analog_input_digital_off
);
    logic [7:0] dda_r, pta_r, ddb_r, ptb_r;
    logic poff_r;
    wire wr = psel & penable & pwrite;
    // Shadow of the register state, tracked from the bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {dda_r, pta_r, ddb_r, ptb_r, poff_r} <= '0;
        else if (wr)
            case (paddr)
                PAO_OFF_A_DIR: dda_r <= pwdata[7:0];
                PAO_OFF_A_LAT: pta_r <= pwdata[7:0];
                PAO_OFF_A_LVL: pta_r <= pta_r ^ pwdata[7:0];
                PAO_OFF_B_DIR: ddb_r <= pwdata[7:0];
                PAO_OFF_B_LAT: ptb_r <= pwdata[7:0];
                PAO_OFF_B_LVL: ptb_r <= ptb_r ^ pwdata[7:0];
                PAO_OFF_CTRL: poff_r <= pwdata[PAO_PULL_OFF_BIT];
                default: ;
            endcase
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_poff_write;
        psel && !penable ##1 wr && paddr == PAO_OFF_CTRL && pwdata[PAO_PULL_OFF_BIT];
    endsequence
    AST_POFF_WR: assert property (s_poff_write |=> (port_a_pullup | port_b_pullup) == 8'h00)
        else $error("pull-up after disable write");
    AST_POFF: assert property (poff_r |-> !(|{port_a_pullup, port_b_pullup}))
        else $error("pull-up while disabled");
    AST_A1_DO: assert property (three_wire_mode_active && serial_pin_remap && dda_r[1]
        |-> !port_a_oe_n[1] && port_a_out[1] == serial_data_out) else $error("a1 serial out");
    AST_A1_PU: assert property (three_wire_mode_active && !dda_r[1] && pta_r[1] && !poff_r
        |-> port_a_pullup[1]) else $error("a1 pull-up lost");
    AST_A2_DIR: assert property (two_wire_mode_active && serial_pin_remap
        |-> port_a_oe_n[2] == !((clock_line_hold | ptb_r[2]) & ddb_r[2])) else $error("a2 dir");
    AST_A0_OUT: assert property (two_wire_mode_active && serial_pin_remap && dda_r[0]
        && ddb_r[0] |-> !port_a_out[0]) else $error("a0 out value");
    AST_A7_3_OE: assert property (port_a_oe_n[7:3] == ~dda_r[7:3])
        else $error("a7..a3 direction");
    AST_A7_3_PU: assert property (!poff_r |-> port_a_pullup[7:3] == (~dda_r[7:3] & pta_r[7:3]))
        else $error("a7..a3 pull-up");
    AST_DIG_OFF: assert property ((analog_input_digital_off & port_a_digital & 8'hf7) == 8'h00)
        else $error("digital input not off");
    AST_A3_DIN: assert property (pin_change_enable && pin_change_mask_a[3]
        |-> port_a_digital[3] == $past(port_a_in[3], 2)) else $error("a3 input");
endmodule

bind pao_port_top pao_port_props u_props
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .port_a_in, .port_a_out,
    .port_a_oe_n, .port_a_pullup, .port_b_pullup, .port_a_digital, .two_wire_mode_active,
    .three_wire_mode_active, .serial_pin_remap, .clock_line_hold, .serial_data_out,
    .pin_change_enable, .pin_change_mask_a, .analog_input_digital_off
);

// >>> dv/pao_pin_model.sv
module pao_pin_model
(
    input wire logic [7:0] oe_n,
    input wire logic [7:0] drv,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    timeunit 1ns;
    timeprecision 1ps;
    // pad level from driver, far end, then pull-up
    // Floating pins read low: a weak pull-down is assumed
    assign level = (~oe_n & drv) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & pull_en);
endmodule

// >>> dv/port_a_alt_function_override_tb.sv
module port_a_alt_function_override_tb
    import pao_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, tgr, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [7:0] pa_in, pa_out, pa_oe, pa_pu, pb_in, pb_out, pb_oe, pb_pu, pa_dig;
    logic [7:0] ext_en = 0, ext_val = 0, pcm = 0, aoff = 0;
    logic tw = 0, thw = 0, rmp = 0, hold = 0, tog = 0, sie = 0, sdo = 0, sda = 0, pce = 0, irq = 0;
    logic [31:0] addrs[5] = '{PAO_OFF_B_DIR, PAO_OFF_B_LAT, PAO_OFF_A_DIR, PAO_OFF_A_LAT, PAO_OFF_CTRL};
    int errors = 0, num_checks = 0;
    always #2 pclk = ~pclk;
    pao_port_top uut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_in(pa_in), .port_a_out(pa_out), .port_a_oe_n(pa_oe), .port_a_pullup(pa_pu),
        .port_b_in(pb_in), .port_b_out(pb_out), .port_b_oe_n(pb_oe), .port_b_pullup(pb_pu),
        .port_a_digital(pa_dig), .port_b_digital(), .toggle_request(tgr),
        .two_wire_mode_active(tw), .three_wire_mode_active(thw), .serial_pin_remap(rmp),
        .clock_line_hold(hold), .serial_toggle_enable(tog), .start_detect_irq_enable(sie),
        .serial_data_out(sdo), .serial_sda_out(sda), .pin_change_enable(pce),
        .pin_change_mask_a(pcm), .external_irq1_input(irq), .analog_input_digital_off(aoff)
    );
    pao_pin_model u_pa (.oe_n(pa_oe), .drv(pa_out), .pull_en(pa_pu), .ext_en(ext_en),
        .ext_val(ext_val), .level(pa_in));
    pao_pin_model u_pb (.oe_n(pb_oe), .drv(pb_out), .pull_en(pb_pu), .ext_en(8'h00),
        .ext_val(8'h00), .level(pb_in));
    task automatic stop_test();
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Slave may stretch the access; bounded wait
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 20)
        begin
            errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, addrs[i], 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, addrs[i], 32'ha5);
            apb(1'b0, addrs[i], 32'h0);
            chk(rd, (i == 4) ? {24'h0, 8'ha5 & PAO_CTRL_WMASK} : 32'ha5);
            apb(1'b1, addrs[i], 32'h0);
        end
        apb(1'b0, 32'h0000_0100, 32'h0);
        chk({rd, err}, {32'h0, 1'b1});
        apb(1'b1, PAO_OFF_A_LAT, 32'hff);
        apb(1'b1, PAO_OFF_B_LAT, 32'hff);
        settle();
        chk({pb_pu, pa_pu}, 32'hffff);
        apb(1'b1, PAO_OFF_CTRL, 32'h40);
        settle();
        chk({pb_pu, pa_pu, pa_in}, 32'h0);
        apb(1'b1, PAO_OFF_CTRL, 32'h0);
        @(posedge pclk);
        {thw, rmp, ext_en} <= {2'b11, 8'h01};
        settle();
        chk(pa_pu[1], 1'b1);
        apb(1'b1, PAO_OFF_A_DIR, 32'h02);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge pclk);
            {sdo, ext_val} <= {v[0], 7'h0, v[0]};
            settle();
            chk({pa_oe[1], pa_out[1], pa_dig[0]}, {1'b0, v[0], v[0]});
        end
        @(posedge pclk);
        {thw, ext_en, ext_val, pce, pcm, sie, irq} <= {1'b0, 8'hff, 8'h5a, 1'b1, 8'hff, 2'b11};
        apb(1'b1, PAO_OFF_A_DIR, 32'h0);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge pclk);
            aoff <= (k == 0) ? 8'hf7 : 8'h00;
            settle();
            chk(pa_dig, 8'h5a & ~aoff);
        end
        @(posedge pclk);
        {tw, ext_en} <= {1'b1, 8'h00};
        apb(1'b1, PAO_OFF_B_DIR, 32'h05);
        apb(1'b1, PAO_OFF_B_LAT, 32'h0);
        apb(1'b1, PAO_OFF_A_DIR, 32'h01);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge pclk);
            {hold, tog} <= {v[0], v[0]};
            settle();
            chk({pa_oe[2], pa_out[0], tgr}, {!v[0], 1'b0, v[0]});
        end
        stop_test();
    end
endmodule
